// ===== rtl/priority_interrupt_unit_pkg.sv
package priority_interrupt_unit_pkg;
  localparam int LEVEL_W = 4;
  localparam int NUM_EXT = 6;
  localparam int NUM_PERIPH = 24;
  localparam int NUM_PRIO_REGS = 8;
  localparam int SRC_W = 5;
  localparam logic [SRC_W-1:0] SRC_NMI = 5'h00;
  localparam logic [SRC_W-1:0] SRC_EXT_BASE = 5'h01;
  localparam logic [SRC_W-1:0] SRC_PERIPH_BASE = 5'h07;
  localparam logic [4:0] NMI_PRIORITY = 5'h10;
  localparam logic [LEVEL_W-1:0] NMI_CORE_LEVEL = 4'hf;
  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_PRIORITY_SET_A = 32'hffff_8348;
  localparam logic [31:0] IDX_PRIORITY_SET_B = 32'hffff_834a;
  localparam logic [31:0] IDX_PRIORITY_SET_C = 32'hffff_834c;
  localparam logic [31:0] IDX_PRIORITY_SET_D = 32'hffff_834e;
  localparam logic [31:0] IDX_PRIORITY_SET_E = 32'hffff_8350;
  localparam logic [31:0] IDX_PRIORITY_SET_F = 32'hffff_8352;
  localparam logic [31:0] IDX_PRIORITY_SET_G = 32'hffff_8354;
  localparam logic [31:0] IDX_PRIORITY_SET_H = 32'hffff_8356;
  localparam logic [31:0] IDX_INTERRUPT_CONTROL = 32'hffff_8358;
  localparam logic [31:0] IDX_EXTERNAL_REQUEST_FLAGS = 32'hffff_835a;
  localparam logic [15:0] PRIORITY_RESET = 16'h0000;
  localparam logic [15:0] PRIORITY_SET_B_MASK = 16'h00ff;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam int CTRL_NMI_LEVEL_BIT = 15;
  localparam int CTRL_NMI_EDGE_BIT = 8;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h01f3;
  // bit of each external pin (0..3, 6, 7) in control and flag registers
  localparam int EXT_BIT [NUM_EXT] = '{7, 6, 5, 4, 1, 0};
endpackage : priority_interrupt_unit_pkg

// ===== rtl/request_detect.sv
`timescale 1ns/100ps
module request_detect #(
  parameter int N = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] pin_async,
  input wire logic [N-1:0] sense_edge,
  input wire logic [N-1:0] accept,
  input wire logic read_flags,
  input wire logic [N-1:0] write_zero,
  output logic [N-1:0] pin_low,
  output logic [N-1:0] flag
);
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;
  logic [N-1:0] edge_latch;
  logic [N-1:0] seen_one;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      sync2 <= '1;
      prev <= '1;
    end else begin
      sync1 <= pin_async;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  generate
    if (N < 1) begin : g_chk
      $error("at least one request pin is needed");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic fall;
      logic clr;
      assign fall = prev[i] & ~sync2[i];
      assign clr = accept[i] | (write_zero[i] & seen_one[i]);
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          edge_latch[i] <= 1'b0;
        end else if (sense_edge[i] && fall) begin
          edge_latch[i] <= 1'b1;
        end else if (clr || !sense_edge[i]) begin
          edge_latch[i] <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          seen_one[i] <= 1'b0;
        end else if (read_flags) begin
          seen_one[i] <= flag[i];
        end else if (clr || !sense_edge[i]) begin
          seen_one[i] <= 1'b0;
        end
      end
      assign pin_low[i] = ~sync2[i];
      assign flag[i] = sense_edge[i] ? edge_latch[i] : ~sync2[i];
    end
  endgenerate
endmodule : request_detect

// ===== rtl/priority_select.sv
`timescale 1ns/100ps
module priority_select #(
  parameter int N = 30,
  parameter int LW = 4,
  parameter int IW = 5
) (
  input wire logic [N-1:0] req,
  input wire logic [N*LW-1:0] levels,
  output logic any,
  output logic [IW-1:0] idx,
  output logic [LW-1:0] level
);
  generate
    if (N < 1 || LW < 1 || N > 2 ** IW) begin : g_chk
      $error("source count or field widths not served");
    end
  endgenerate

  always_comb begin
    any = 1'b0;
    idx = '0;
    level = '0;
    for (int i = 0; i < N; i++) begin
      // strictly greater keeps the lower index on a tie
      if (req[i] && levels[i*LW +: LW] != '0 && levels[i*LW +: LW] > level) begin
        any = 1'b1;
        idx = IW'(i);
        level = levels[i*LW +: LW];
      end
    end
  end
endmodule : priority_select

// ===== rtl/priority_interrupt_unit.sv
`timescale 1ns/100ps
module priority_interrupt_unit
  import priority_interrupt_unit_pkg::*;
#(
  parameter int NUM_PERIPH_SRC = priority_interrupt_unit_pkg::NUM_PERIPH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic nmi_pin,
  input wire logic [3:0] external_request_pins_low,
  input wire logic [1:0] external_request_pins_high,
  input wire logic [NUM_PERIPH_SRC-1:0] peripheral_req,
  input wire logic [priority_interrupt_unit_pkg::LEVEL_W-1:0] core_mask_level,
  input wire logic core_delay_slot,
  input wire logic core_after_reg_transfer,
  input wire logic core_accept,
  input wire logic core_address_error,
  output logic irq_request,
  output logic [priority_interrupt_unit_pkg::LEVEL_W-1:0] irq_level,
  output logic [priority_interrupt_unit_pkg::SRC_W-1:0] irq_source,
  output logic irq_nonmaskable,
  output logic address_error_take
);
  import priority_interrupt_unit_pkg::*;

  localparam int NUM_SRC = NUM_EXT + NUM_PERIPH_SRC;

  generate
    if (NUM_PERIPH_SRC < 1 || NUM_PERIPH_SRC > 4 * (NUM_PRIO_REGS - 2)) begin : g_chk
      $error("peripheral source count not served by priority registers");
    end
    if (int'(SRC_EXT_BASE) + NUM_SRC > 2 ** SRC_W) begin : g_chk_src
      $error("source index field too narrow for the source count");
    end
  endgenerate

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

  bus_state_e bus_state;
  logic [15:0] priority_set [NUM_PRIO_REGS];
  logic [15:0] interrupt_control;
  logic nmi_sync1;
  logic nmi_sync2;
  logic nmi_prev;
  logic nmi_pending;
  logic nmi_edge;
  logic [NUM_EXT-1:0] ext_pins;
  logic [NUM_EXT-1:0] ext_sense_edge;
  logic [NUM_EXT-1:0] ext_flag;
  logic [NUM_EXT-1:0] ext_pin_low;
  logic [NUM_EXT-1:0] ext_accept;
  logic [NUM_EXT-1:0] ext_write_zero;
  logic [15:0] flags_view;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC*LEVEL_W-1:0] src_levels;
  logic win_any;
  logic [SRC_W-1:0] win_idx;
  logic [LEVEL_W-1:0] win_level;
  logic int_blocked;
  logic maskable_ok;
  logic bus_take;
  logic bus_wr;
  logic bus_rd;
  logic [15:0] wr_data;
  logic [15:0] wr_keep;
  logic [15:0] next_readdata;
  logic [2:0] prio_sel;
  logic prio_hit;
  logic ctrl_hit;
  logic flags_hit;
  logic aerr_held;

  // avalon slave: one answer cycle with waitrequest low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_state == BUS_IDLE && (avs_read || avs_write));
    end
  end

  assign bus_take = (bus_state == BUS_ANSWER) && !avs_waitrequest;
  assign bus_wr = bus_take && avs_write;
  assign bus_rd = (bus_state == BUS_IDLE) && avs_read;

  always_comb begin
    prio_hit = 1'b0;
    prio_sel = 3'h0;
    for (int r = 0; r < NUM_PRIO_REGS; r++) begin
      if (avs_address == IDX_PRIORITY_SET_A + 32'(2 * r)) begin
        prio_hit = 1'b1;
        prio_sel = 3'(r);
      end
    end
  end

  assign ctrl_hit = (avs_address == IDX_INTERRUPT_CONTROL);
  assign flags_hit = (avs_address == IDX_EXTERNAL_REQUEST_FLAGS);
  assign wr_keep = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_data = avs_writedata[15:0];

  // priority registers, each field sets one source level except the upper byte of B, which sets none
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < NUM_PRIO_REGS; r++) begin
        priority_set[r] <= PRIORITY_RESET;
      end
    end else if (bus_wr && prio_hit) begin
      priority_set[prio_sel] <= (priority_set[prio_sel] & ~wr_keep) | (wr_data & wr_keep);
    end
  end

  // control register; bit 15 is the live pin level, not stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      interrupt_control <= CONTROL_RESET;
    end else if (bus_wr && ctrl_hit) begin
      interrupt_control <= (interrupt_control & ~(wr_keep & CTRL_WRITE_MASK))
        | (wr_data & wr_keep & CTRL_WRITE_MASK);
    end
  end

  always_comb begin
    flags_view = FLAGS_RESET;
    ext_write_zero = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      flags_view[EXT_BIT[e]] = ext_flag[e];
      ext_write_zero[e] = bus_wr && flags_hit && wr_keep[EXT_BIT[e]]
        && !wr_data[EXT_BIT[e]];
      ext_sense_edge[e] = interrupt_control[EXT_BIT[e]];
    end
  end

  always_comb begin
    next_readdata = 16'h0000;
    if (prio_hit) begin
      next_readdata = priority_set[prio_sel];
      if (prio_sel == 3'h1) begin
        next_readdata = priority_set[prio_sel] & PRIORITY_SET_B_MASK;
      end
    end else if (ctrl_hit) begin
      next_readdata = interrupt_control;
      next_readdata[CTRL_NMI_LEVEL_BIT] = nmi_sync2;
    end else if (flags_hit) begin
      next_readdata = flags_view;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      avs_readdata <= {16'h0000, next_readdata};
    end
  end

  // nonmaskable pin: synchronise, pick edge, latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_sync1 <= 1'b0;
      nmi_sync2 <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      nmi_sync1 <= nmi_pin;
      nmi_sync2 <= nmi_sync1;
      nmi_prev <= nmi_sync2;
    end
  end

  assign nmi_edge = interrupt_control[CTRL_NMI_EDGE_BIT]
    ? (nmi_sync2 && !nmi_prev) : (!nmi_sync2 && nmi_prev);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_pending <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pending <= 1'b1;
    end else if (core_accept && irq_nonmaskable) begin
      nmi_pending <= 1'b0;
    end
  end

  // external pins
  assign ext_pins = {external_request_pins_high, external_request_pins_low};

  always_comb begin
    ext_accept = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_accept[e] = core_accept && !irq_nonmaskable
        && irq_source == SRC_EXT_BASE + SRC_W'(e);
    end
  end

  request_detect #(
    .N(NUM_EXT)
  ) u_detect (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_async(ext_pins),
    .sense_edge(ext_sense_edge),
    .accept(ext_accept),
    .read_flags(bus_rd && flags_hit),
    .write_zero(ext_write_zero),
    .pin_low(ext_pin_low),
    .flag(ext_flag)
  );

  // source vector with one level field per source
  genvar s;
  generate
    for (s = 0; s < NUM_EXT; s++) begin : g_ext_src
      localparam int REG = (s < 4) ? 0 : 1;
      localparam int FLD = (s < 4) ? (3 - s) : (5 - s);
      assign src_req[s] = ext_sense_edge[s] ? ext_flag[s] : ext_pin_low[s];
      assign src_levels[s*LEVEL_W +: LEVEL_W] = priority_set[REG][FLD*LEVEL_W +: LEVEL_W];
    end
    for (s = 0; s < NUM_PERIPH_SRC; s++) begin : g_per_src
      localparam int REG = 2 + s / 4;
      localparam int FLD = 3 - (s % 4);
      assign src_req[NUM_EXT + s] = peripheral_req[s];
      assign src_levels[(NUM_EXT + s)*LEVEL_W +: LEVEL_W] =
        priority_set[REG][FLD*LEVEL_W +: LEVEL_W];
    end
  endgenerate

  priority_select #(
    .N(NUM_SRC),
    .LW(LEVEL_W),
    .IW(SRC_W)
  ) u_select (
    .req(src_req),
    .levels(src_levels),
    .any(win_any),
    .idx(win_idx),
    .level(win_level)
  );

  assign int_blocked = core_delay_slot || core_after_reg_transfer;
  assign maskable_ok = win_any && (win_level > core_mask_level);

  // presented request is registered; blocked sources stay latched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_request <= 1'b0;
      irq_level <= '0;
      irq_source <= SRC_NMI;
      irq_nonmaskable <= 1'b0;
    end else if (core_accept || int_blocked) begin
      irq_request <= 1'b0;
    end else if (nmi_pending) begin
      irq_request <= 1'b1;
      irq_level <= NMI_CORE_LEVEL;
      irq_source <= SRC_NMI;
      irq_nonmaskable <= 1'b1;
    end else begin
      irq_request <= maskable_ok;
      irq_level <= win_level;
      irq_source <= SRC_EXT_BASE + win_idx;
      irq_nonmaskable <= 1'b0;
    end
  end

  // an address error raised in the delay slot is kept until the slot ends
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aerr_held <= 1'b0;
    end else if (core_delay_slot && core_address_error) begin
      aerr_held <= 1'b1;
    end else if (!core_delay_slot) begin
      aerr_held <= 1'b0;
    end
  end

  // address errors wait only during the delay slot
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      address_error_take <= 1'b0;
    end else begin
      address_error_take <= (core_address_error || aerr_held) && !core_delay_slot;
    end
  end
endmodule : priority_interrupt_unit

// ===== dv/priority_interrupt_unit_props.sv
`timescale 1ns/100ps
module priority_interrupt_unit_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] core_mask_level,
  input wire logic core_delay_slot,
  input wire logic core_after_reg_transfer,
  input wire logic core_accept,
  input wire logic core_address_error,
  input wire logic irq_request,
  input wire logic [3:0] irq_level,
  input wire logic [4:0] irq_source,
  input wire logic irq_nonmaskable,
  input wire logic address_error_take
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  slot_blocks_irq_a: assert property (core_delay_slot |=> !irq_request)
    else $error("request shown in delay slot");
  slot_blocks_err_a: assert property (core_delay_slot |=> !address_error_take)
    else $error("address error taken in delay slot");
  xfer_blocks_irq_a: assert property (core_after_reg_transfer |=> !irq_request)
    else $error("request shown after register transfer");
  xfer_takes_err_a: assert property
    (core_address_error && !core_delay_slot |=> address_error_take)
    else $error("address error not taken");
  accept_drops_a: assert property (core_accept |=> !irq_request)
    else $error("request kept after accept");
  nmi_level_a: assert property
    (irq_request && irq_nonmaskable |-> irq_level == 4'hf && irq_source == 5'h00)
    else $error("nonmaskable level or source wrong");
  nmi_source_a: assert property (irq_request && irq_source == 5'h00 |-> irq_nonmaskable)
    else $error("source zero not nonmaskable");
  level_nonzero_a: assert property (irq_request && !irq_nonmaskable |-> irq_level != 4'h0)
    else $error("level zero source forwarded");
  above_mask_a: assert property
    (irq_request && !irq_nonmaskable |-> irq_level > $past(core_mask_level))
    else $error("request not above mask");
  source_range_a: assert property (irq_request |-> irq_source <= 5'h1e)
    else $error("source index out of range");
  bus_one_wait_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait");
  nmi_seen_c: cover property (irq_request && irq_nonmaskable);
  accept_seen_c: cover property (core_accept);
  slot_pending_c: cover property (core_delay_slot && irq_request);
endmodule : priority_interrupt_unit_props
bind priority_interrupt_unit priority_interrupt_unit_props u_priority_interrupt_unit_props (.clk_sys, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .core_mask_level, .core_delay_slot, .core_after_reg_transfer,
  .core_accept, .core_address_error, .irq_request, .irq_level, .irq_source,
  .irq_nonmaskable, .address_error_take);

// ===== dv/core_model.sv
`timescale 1ns/100ps
module core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic irq_request,
  input wire logic [3:0] irq_level,
  input wire logic accept_en,
  input wire logic mask_wr,
  input wire logic [3:0] mask_val,
  output logic core_accept,
  output logic [3:0] core_mask_level
);
  // one-cycle acceptance of a presented request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_accept <= 1'b0;
    end else begin
      core_accept <= accept_en && irq_request && !core_accept;
    end
  end
  // mask takes the accepted level, fifteen for nonmaskable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_mask_level <= 4'h0;
    end else if (mask_wr) begin
      core_mask_level <= mask_val;
    end else if (core_accept) begin
      core_mask_level <= irq_level;
    end
  end
endmodule : core_model

// ===== dv/priority_interrupt_unit_test.sv
`timescale 1ns/100ps
module priority_interrupt_unit_test;
  import priority_interrupt_unit_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] avs_address = 32'h0000_0000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_waitrequest;
  logic nmi_pin = 1'b0;
  logic slot = 1'b0;
  logic xfer = 1'b0;
  logic aerr = 1'b0;
  logic acc_en = 1'b0;
  logic mask_wr = 1'b0;
  logic [3:0] mask_val = 4'h0;
  logic [3:0] be = 4'h3;
  logic [3:0] ext_lo = 4'hf;
  logic [1:0] ext_hi = 2'h3;
  logic [23:0] preq = 24'h00_0000;
  logic [3:0] core_mask_level;
  logic [3:0] irq_level;
  logic [4:0] irq_source;
  logic core_accept;
  logic irq_request;
  logic irq_nonmaskable;
  logic address_error_take;
  logic [31:0] q;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  priority_interrupt_unit #(.NUM_PERIPH_SRC(24)) u_priority_interrupt_unit (.clk_sys, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(be),
    .avs_readdata, .avs_waitrequest, .nmi_pin, .external_request_pins_low(ext_lo),
    .external_request_pins_high(ext_hi), .peripheral_req(preq), .core_mask_level,
    .core_delay_slot(slot), .core_after_reg_transfer(xfer), .core_accept,
    .core_address_error(aerr), .irq_request, .irq_level, .irq_source, .irq_nonmaskable,
    .address_error_take);
  core_model u_core_model (.clk_sys, .rst, .irq_request, .irq_level, .accept_en(acc_en),
    .mask_wr, .mask_val, .core_accept, .core_mask_level);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= ~w;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      give_verdict();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    check(q, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic irq(input logic [3:0] l, input logic [4:0] s);
    check({irq_request, irq_level, irq_source}, {1'b1, l, s});
  endtask : irq
  task automatic set_mask(input logic [3:0] v);
    @(posedge clk_sys);
    mask_val <= v;
    mask_wr <= 1'b1;
    @(posedge clk_sys);
    mask_wr <= 1'b0;
  endtask : set_mask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(IDX_PRIORITY_SET_A + 32'(2 * i), 16'h0000);
    rd(32'hffff_835c, 16'h0000);
    wr(IDX_PRIORITY_SET_B, 16'hffff);
    rd(IDX_PRIORITY_SET_B, 16'h00ff);
    @(posedge clk_sys) be <= 4'h2;
    wr(IDX_PRIORITY_SET_A, 16'h1234);
    rd(IDX_PRIORITY_SET_A, 16'h1200);
    @(posedge clk_sys) be <= 4'h3;
    wr(IDX_PRIORITY_SET_A, 16'h4000);
    rd(IDX_PRIORITY_SET_A, 16'h4000);
    @(posedge clk_sys) ext_lo <= 4'he;
    cyc(6);
    irq(4'h4, 5'h01);
    rd(IDX_EXTERNAL_REQUEST_FLAGS, 16'h0080);
    @(posedge clk_sys) ext_lo <= 4'hf;
    cyc(6);
    check(irq_request, 1'b0);
    wr(IDX_INTERRUPT_CONTROL, 16'h0080);
    @(posedge clk_sys) ext_lo <= 4'he;
    cyc(3);
    @(posedge clk_sys) ext_lo <= 4'hf;
    cyc(6);
    irq(4'h4, 5'h01);
    wr(IDX_EXTERNAL_REQUEST_FLAGS, 16'h0000);
    rd(IDX_EXTERNAL_REQUEST_FLAGS, 16'h0080);
    wr(IDX_EXTERNAL_REQUEST_FLAGS, 16'h0000);
    rd(IDX_EXTERNAL_REQUEST_FLAGS, 16'h0000);
    cyc(3);
    check(irq_request, 1'b0);
    wr(IDX_PRIORITY_SET_C, 16'h5500);
    set_mask(4'h3);
    @(posedge clk_sys) preq <= 24'h00_0003;
    cyc(3);
    irq(4'h5, 5'h07);
    wr(IDX_PRIORITY_SET_D, 16'h9000);
    @(posedge clk_sys) preq <= 24'h00_0013;
    cyc(3);
    irq(4'h9, 5'h0b);
    @(posedge clk_sys) preq <= 24'h00_0004;
    cyc(3);
    check(irq_request, 1'b0);
    set_mask(4'h9);
    @(posedge clk_sys) preq <= 24'h00_0010;
    cyc(3);
    check(irq_request, 1'b0);
    set_mask(4'h8);
    cyc(3);
    irq(4'h9, 5'h0b);
    @(posedge clk_sys) slot <= 1'b1;
    @(posedge clk_sys) aerr <= 1'b1;
    cyc(2);
    check({irq_request, address_error_take}, 2'b00);
    @(posedge clk_sys) slot <= 1'b0;
    @(posedge clk_sys) xfer <= 1'b1;
    cyc(2);
    check({irq_request, address_error_take}, 2'b01);
    @(posedge clk_sys) xfer <= 1'b0;
    @(posedge clk_sys) aerr <= 1'b0;
    cyc(2);
    irq(4'h9, 5'h0b);
    @(posedge clk_sys) slot <= 1'b1;
    @(posedge clk_sys) aerr <= 1'b1;
    @(posedge clk_sys) aerr <= 1'b0;
    @(posedge clk_sys) slot <= 1'b0;
    cyc(2);
    check({irq_request, address_error_take}, 2'b11);
    @(posedge clk_sys) acc_en <= 1'b1;
    cyc(4);
    check({core_mask_level, irq_request}, {4'h9, 1'b0});
    @(posedge clk_sys) acc_en <= 1'b0;
    @(posedge clk_sys) preq <= 24'h00_0000;
    wr(IDX_INTERRUPT_CONTROL, 16'h0100);
    set_mask(4'hf);
    @(posedge clk_sys) nmi_pin <= 1'b1;
    cyc(6);
    irq(4'hf, 5'h00);
    check(irq_nonmaskable, 1'b1);
    rd(IDX_INTERRUPT_CONTROL, 16'h8100);
    set_mask(4'h2);
    @(posedge clk_sys) acc_en <= 1'b1;
    cyc(4);
    check({core_mask_level, irq_request}, {4'hf, 1'b0});
    @(posedge clk_sys) nmi_pin <= 1'b0;
    cyc(6);
    check(irq_request, 1'b0);
    rd(IDX_INTERRUPT_CONTROL, 16'h0100);
    @(posedge clk_sys) nmi_pin <= 1'b1;
    @(posedge clk_sys) rst <= 1'b1;
    cyc(2);
    @(posedge clk_sys) rst <= 1'b0;
    cyc(4);
    rd(IDX_INTERRUPT_CONTROL, 16'h8000);
    give_verdict();
  end
endmodule : priority_interrupt_unit_test
